//--- hw/swk_regs.vh
`ifndef WAKE_CONFIG_REGS_VH
`define WAKE_CONFIG_REGS_VH

// ==========================================================
// Register addresses on the 7-bit register port
// ==========================================================
`define ADDR_SELECTIVE_WAKE_CONTROL 7'h20
`define ADDR_BIT_TIME_QUANTA_COUNT 7'h21
`define ADDR_SAMPLING_POINT_POSITION 7'h22
`define ADDR_WAKE_IDENTIFIER_BYTE3 7'h23
`define ADDR_WAKE_IDENTIFIER_BYTE2 7'h24
`define ADDR_WAKE_IDENTIFIER_BYTE1 7'h25
`define ADDR_WAKE_IDENTIFIER_LOW_FLAGS 7'h26
`define ADDR_WAKE_IDENTIFIER_MASK_BYTE3 7'h27
`define ADDR_CLOCK_RECOVERY_CONTROL2 7'h3e
`define ADDR_WAKE_RECEIVER_OPTION 7'h3f

// ==========================================================
// Reset values (power-on and soft reset)
// ==========================================================
`define RST_SELECTIVE_WAKE_CONTROL 8'h00
`define RST_BIT_TIME_QUANTA_COUNT 8'ha0
`define RST_SAMPLING_POINT_POSITION 8'h33
`define RST_SAMPLE_POINT_FIELD 6'h33
`define RST_IDENTIFIER 8'h00
`define RST_MASK 8'h00
`define RST_CLOCK_RECOVERY_CONTROL2 8'h00
`define RST_WAKE_RECEIVER_OPTION 8'h00

// ==========================================================
// Field positions
// ==========================================================
`define BIT_OSC_CALIBRATION_ENABLE 7
`define BIT_UNLOCK_HI 6
`define BIT_UNLOCK_LO 5
`define BIT_TIMEOUT_IRQ_ENABLE 4
`define BIT_CONFIG_VALID 0
`define UNLOCK_CODE 2'h3
`define MASK_CTRL_READ 8'hf1
`define MASK_SAMPLE_READ 8'h3f
`define MASK_LOW_FLAGS_READ 8'h7f
`define MASK_CDR2_READ 8'h03
`define MASK_OPTION_READ 8'h01
`define MASK_RESTART_KEEP 8'hf0
`define BIT_RTR 1
`define BIT_IDE 0

// ==========================================================
// Timing
// ==========================================================
`define SAMPLE_FRACTION_SHIFT 6
`define TRIM_COUNT_WIDTH 16

`endif

//--- hw/osc_trim_sync.v
`timescale 1ns/1ns
`include "swk_regs.vh"

// ==========================================================
// Oscillator trim reference: period of the transmit pin
// ==========================================================
module osc_trim_sync #(
  parameter W = `TRIM_COUNT_WIDTH
) (
  input wire clk,
  input wire rst,
  input wire trim_run,
  input wire transmit_data_pin,
  output reg [W-1:0] trim_period,
  output reg trim_update,
  output reg cal_active
);

  reg txd_last;
  reg seen_edge;
  reg [W-1:0] period_count;
  wire rise;

  assign rise = transmit_data_pin & ~txd_last;

  // Count clocks between rising edges of the reference pin
  always @(posedge clk) begin
    if (rst) begin
      txd_last <= 1'b1; // Pin idles high, so no false edge after reset
      seen_edge <= 1'b0;
      period_count <= {W{1'b0}};
      trim_period <= {W{1'b0}};
      trim_update <= 1'b0;
      cal_active <= 1'b0;
    end else begin
      txd_last <= transmit_data_pin;
      cal_active <= trim_run;
      trim_update <= 1'b0;
      if (!trim_run) begin
        // First period after enable is partial, so it is thrown away
        seen_edge <= 1'b0;
        period_count <= {W{1'b0}};
      end else if (rise) begin
        seen_edge <= 1'b1;
        period_count <= {{(W-1){1'b0}}, 1'b1};
        if (seen_edge) begin
          trim_period <= period_count;
          trim_update <= 1'b1;
        end
      end else if (period_count != {W{1'b1}}) begin
        period_count <= period_count + {{(W-1){1'b0}}, 1'b1}; // Saturates on a stuck pin
      end
    end
  end

endmodule

//--- hw/bit_sample_timer.v
`timescale 1ns/1ns
`include "swk_regs.vh"

// ==========================================================
// Time quantum prescaler and bit sample position
// ==========================================================
module bit_sample_timer (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [1:0] quanta_clock_select,
  input wire [7:0] quanta_per_bit,
  input wire [5:0] sample_point_fraction,
  output reg sample_strobe,
  output reg bit_strobe
);

  reg [2:0] prescale;
  reg [7:0] quanta;
  reg [2:0] next_prescale;
  wire [13:0] product;
  wire [7:0] sample_quantum;
  wire quantum_tick;

  // Quantum length is 2^select clocks
  assign quantum_tick = (prescale == ((3'h1 << quanta_clock_select) - 3'h1));
  assign product = quanta_per_bit * sample_point_fraction;
  assign sample_quantum = product[13:6];

  always @* begin
    next_prescale = quantum_tick ? 3'h0 : prescale + 3'h1;
  end

  // Quantum counter within one bit time
  always @(posedge clk) begin
    if (rst || !run) begin
      prescale <= 3'h0;
      quanta <= 8'h00;
      sample_strobe <= 1'b0;
      bit_strobe <= 1'b0;
    end else begin
      prescale <= next_prescale;
      sample_strobe <= 1'b0;
      bit_strobe <= 1'b0;
      if (quantum_tick) begin
        sample_strobe <= (quanta == sample_quantum);
        // A zero count would never wrap, so treat it as one quantum
        if (quanta + 8'h01 >= quanta_per_bit) begin
          quanta <= 8'h00;
          bit_strobe <= 1'b1;
        end else begin
          quanta <= quanta + 8'h01;
        end
      end
    end
  end

endmodule

//--- hw/can_selective_wake_config.v
// Operation
// - Calibration bit 7 enables oscillator calibration
// - Only unlock code 11 unlocks recalibration
// - Transmit pin is the trim reference
// - Option register writable only when unlocked
// - Bit 4 gates time-out onto interrupt
// - Time-out flag sets only with wake enabled
// - Selective wake enabled only while valid set
// - Valid cleared on wake, reset, changes
// - Stop-mode config write clears valid bit
// - Reserved bits always read zero
// - Quanta count byte, default a0
// - Quantum length follows quanta clock select
// - Six-bit sample point, default 33
// - Identifier spread over four registers
// - Standard identifier uses bits 28..18
// - Bit 1 holds expected RTR
// - Bit 0 selects identifier length
// - Mask one compares, zero ignores bit
// - Restart keeps upper nibble of control
`timescale 1ns/1ns
`include "swk_regs.vh"

module can_selective_wake_config #(
  parameter TRIM_WIDTH = `TRIM_COUNT_WIDTH
) (
  input wire CLK,
  input wire RST,
  input wire SOFT_RESET,
  input wire RESTART,
  input wire MODE_NORMAL,
  input wire MODE_STOP,
  input wire WAKE_EVENT,
  input wire CAN_CONFIG_WRITE,
  input wire [6:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  input wire BUS_TIMEOUT_EVENT,
  input wire BUS_TIMEOUT_CLEAR,
  output reg BUS_TIMEOUT_FLAG,
  output reg INT_PULSE,
  output reg SELECTIVE_WAKE_EN,
  output reg ALT_RECEIVER_EN,
  input wire TRANSMIT_DATA_PIN,
  output wire CAL_ACTIVE,
  output wire [TRIM_WIDTH-1:0] TRIM_PERIOD,
  output wire TRIM_UPDATE,
  output wire SAMPLE_STROBE,
  output wire BIT_STROBE,
  input wire RX_FRAME_VALID,
  input wire [28:0] RX_IDENTIFIER,
  input wire RX_RTR,
  input wire RX_IDE,
  output reg WAKE_FRAME_MATCH
);

  // ========================================================
  // Register storage
  // ========================================================
  reg [7:0] selective_wake_control;
  reg [7:0] bit_time_quanta_count;
  reg [5:0] sample_point_fraction;
  reg [7:0] identifier_high_byte;
  reg [7:0] identifier_mid_byte;
  reg [7:0] identifier_low_byte;
  reg [4:0] identifier_lowest_bits;
  reg expected_rtr;
  reg extended_length;
  reg [7:0] identifier_mask_high_byte;
  reg [1:0] quanta_clock_select;
  reg wake_receiver_option;

  wire osc_calibration_enable;
  wire calibration_unlocked;
  wire timeout_irq_enable;
  wire wake_config_valid;
  wire any_reset;
  wire wr_ctrl;
  wire wr_data_cfg;
  wire wr_option;
  wire config_change;
  wire selective_wake_on;
  wire [28:0] wake_identifier;

  assign any_reset = RST | SOFT_RESET;
  assign osc_calibration_enable = selective_wake_control[`BIT_OSC_CALIBRATION_ENABLE];
  assign timeout_irq_enable = selective_wake_control[`BIT_TIMEOUT_IRQ_ENABLE];
  assign wake_config_valid = selective_wake_control[`BIT_CONFIG_VALID];
  assign wake_identifier = {identifier_high_byte, identifier_mid_byte,
                            identifier_low_byte, identifier_lowest_bits};

  // Only the full code unlocks; the three other codes stay locked
  assign calibration_unlocked =
    (selective_wake_control[`BIT_UNLOCK_HI:`BIT_UNLOCK_LO] == `UNLOCK_CODE);

  // ========================================================
  // Address decode
  // ========================================================
  function is_data_config;
    input [6:0] addr;
    begin
      is_data_config = (addr >= `ADDR_BIT_TIME_QUANTA_COUNT) &&
                       (addr <= `ADDR_WAKE_IDENTIFIER_MASK_BYTE3) ||
                       (addr == `ADDR_CLOCK_RECOVERY_CONTROL2);
    end
  endfunction

  // Masked compare: a one in the mask means the bit counts
  function masked_equal;
    input [7:0] a;
    input [7:0] b;
    input [7:0] mask;
    begin
      masked_equal = (((a ^ b) & mask) == 8'h00);
    end
  endfunction

  assign wr_ctrl = REG_WR && (REG_ADDR == `ADDR_SELECTIVE_WAKE_CONTROL);
  assign wr_data_cfg = REG_WR && is_data_config(REG_ADDR);
  // Option writes are dropped silently while locked
  assign wr_option = REG_WR && (REG_ADDR == `ADDR_WAKE_RECEIVER_OPTION) && calibration_unlocked;

  // Any change of wake configuration data invalidates it
  assign config_change = wr_data_cfg || wr_option;

  // ========================================================
  // Control register
  // ========================================================
  always @(posedge CLK) begin
    if (any_reset) begin
      selective_wake_control <= `RST_SELECTIVE_WAKE_CONTROL;
    end else if (RESTART) begin
      selective_wake_control <= selective_wake_control & `MASK_RESTART_KEEP;
    end else begin
      if (wr_ctrl) begin
        selective_wake_control <= REG_WDATA & `MASK_CTRL_READ;
      end
      // Hardware clear beats the software set in the same cycle
      if (WAKE_EVENT || config_change) begin
        selective_wake_control[`BIT_CONFIG_VALID] <= 1'b0;
      end
      if (MODE_STOP && (wr_ctrl || wr_data_cfg || wr_option || CAN_CONFIG_WRITE)) begin
        selective_wake_control[`BIT_CONFIG_VALID] <= 1'b0;
      end
    end
  end

  // ========================================================
  // Timing and identifier registers
  // ========================================================
  // Restart leaves these untouched; only power-on and soft reset load defaults
  always @(posedge CLK) begin
    if (any_reset) begin
      bit_time_quanta_count <= `RST_BIT_TIME_QUANTA_COUNT;
      sample_point_fraction <= `RST_SAMPLE_POINT_FIELD;
      identifier_high_byte <= `RST_IDENTIFIER;
      identifier_mid_byte <= `RST_IDENTIFIER;
      identifier_low_byte <= `RST_IDENTIFIER;
      identifier_lowest_bits <= 5'h00;
      expected_rtr <= 1'b0;
      extended_length <= 1'b0;
      identifier_mask_high_byte <= `RST_MASK;
      quanta_clock_select <= 2'h0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `ADDR_BIT_TIME_QUANTA_COUNT: begin
          bit_time_quanta_count <= REG_WDATA;
        end
        `ADDR_SAMPLING_POINT_POSITION: begin
          sample_point_fraction <= REG_WDATA[5:0];
        end
        `ADDR_WAKE_IDENTIFIER_BYTE3: begin
          identifier_high_byte <= REG_WDATA;
        end
        `ADDR_WAKE_IDENTIFIER_BYTE2: begin
          identifier_mid_byte <= REG_WDATA;
        end
        `ADDR_WAKE_IDENTIFIER_BYTE1: begin
          identifier_low_byte <= REG_WDATA;
        end
        `ADDR_WAKE_IDENTIFIER_LOW_FLAGS: begin
          identifier_lowest_bits <= REG_WDATA[6:2];
          expected_rtr <= REG_WDATA[`BIT_RTR];
          extended_length <= REG_WDATA[`BIT_IDE];
        end
        `ADDR_WAKE_IDENTIFIER_MASK_BYTE3: begin
          identifier_mask_high_byte <= REG_WDATA;
        end
        `ADDR_CLOCK_RECOVERY_CONTROL2: begin
          quanta_clock_select <= REG_WDATA[1:0];
        end
        default: begin
          quanta_clock_select <= quanta_clock_select;
        end
      endcase
    end
  end

  // Option register: alternate low-power receiver
  always @(posedge CLK) begin
    if (any_reset) begin
      wake_receiver_option <= 1'b0;
    end else if (wr_option) begin
      wake_receiver_option <= REG_WDATA[0];
    end
  end

  // ========================================================
  // Read port
  // ========================================================
  // Read data is registered; unmapped addresses return zero
  always @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          `ADDR_SELECTIVE_WAKE_CONTROL: begin
            REG_RDATA <= selective_wake_control & `MASK_CTRL_READ;
          end
          `ADDR_BIT_TIME_QUANTA_COUNT: begin
            REG_RDATA <= bit_time_quanta_count;
          end
          `ADDR_SAMPLING_POINT_POSITION: begin
            REG_RDATA <= {2'b00, sample_point_fraction};
          end
          `ADDR_WAKE_IDENTIFIER_BYTE3: begin
            REG_RDATA <= identifier_high_byte;
          end
          `ADDR_WAKE_IDENTIFIER_BYTE2: begin
            REG_RDATA <= identifier_mid_byte;
          end
          `ADDR_WAKE_IDENTIFIER_BYTE1: begin
            REG_RDATA <= identifier_low_byte;
          end
          `ADDR_WAKE_IDENTIFIER_LOW_FLAGS: begin
            REG_RDATA <= {1'b0, identifier_lowest_bits, expected_rtr, extended_length};
          end
          `ADDR_WAKE_IDENTIFIER_MASK_BYTE3: begin
            REG_RDATA <= identifier_mask_high_byte;
          end
          `ADDR_CLOCK_RECOVERY_CONTROL2: begin
            REG_RDATA <= {6'h00, quanta_clock_select};
          end
          `ADDR_WAKE_RECEIVER_OPTION: begin
            REG_RDATA <= {7'h00, wake_receiver_option};
          end
          default: begin
            REG_RDATA <= 8'h00;
          end
        endcase
      end
    end
  end

  // ========================================================
  // Selective wake enable, time-out flag and interrupt
  // ========================================================
  assign selective_wake_on = wake_config_valid && (MODE_NORMAL || MODE_STOP);

  always @(posedge CLK) begin
    if (any_reset) begin
      SELECTIVE_WAKE_EN <= 1'b0;
      ALT_RECEIVER_EN <= 1'b0;
      BUS_TIMEOUT_FLAG <= 1'b0;
      INT_PULSE <= 1'b0;
    end else begin
      SELECTIVE_WAKE_EN <= selective_wake_on;
      ALT_RECEIVER_EN <= wake_receiver_option;
      // Flag sets only while selective wake is on, where a new event beats a clear; a clear works in any mode
      if (selective_wake_on && BUS_TIMEOUT_EVENT) begin
        BUS_TIMEOUT_FLAG <= 1'b1;
      end else if (BUS_TIMEOUT_CLEAR) begin
        BUS_TIMEOUT_FLAG <= 1'b0;
      end
      INT_PULSE <= selective_wake_on && BUS_TIMEOUT_EVENT && timeout_irq_enable;
    end
  end

  // ========================================================
  // Wake frame identifier compare
  // ========================================================
  // Only the top byte has a mask here; lower bits compare exactly
  always @(posedge CLK) begin
    if (any_reset) begin
      WAKE_FRAME_MATCH <= 1'b0;
    end else begin
      WAKE_FRAME_MATCH <= 1'b0;
      if (RX_FRAME_VALID && SELECTIVE_WAKE_EN) begin
        if (RX_IDE != extended_length || RX_RTR != expected_rtr) begin
          WAKE_FRAME_MATCH <= 1'b0;
        end else if (!extended_length) begin
          // Standard identifiers sit in the top eleven bits
          WAKE_FRAME_MATCH <= masked_equal(RX_IDENTIFIER[28:21], wake_identifier[28:21],
                                           identifier_mask_high_byte) &&
                              (RX_IDENTIFIER[20:18] == wake_identifier[20:18]);
        end else begin
          WAKE_FRAME_MATCH <= masked_equal(RX_IDENTIFIER[28:21], wake_identifier[28:21],
                                           identifier_mask_high_byte) &&
                              (RX_IDENTIFIER[20:0] == wake_identifier[20:0]);
        end
      end
    end
  end

  // ========================================================
  // Oscillator calibration and bit timing
  // ========================================================
  osc_trim_sync #(
    .W(TRIM_WIDTH)
  ) u_trim (
    .clk(CLK),
    .rst(any_reset),
    .trim_run(osc_calibration_enable && calibration_unlocked),
    .transmit_data_pin(TRANSMIT_DATA_PIN),
    .trim_period(TRIM_PERIOD),
    .trim_update(TRIM_UPDATE),
    .cal_active(CAL_ACTIVE)
  );

  bit_sample_timer u_timer (
    .clk(CLK),
    .rst(any_reset),
    .run(SELECTIVE_WAKE_EN),
    .quanta_clock_select(quanta_clock_select),
    .quanta_per_bit(bit_time_quanta_count),
    .sample_point_fraction(sample_point_fraction),
    .sample_strobe(SAMPLE_STROBE),
    .bit_strobe(BIT_STROBE)
  );

endmodule

//--- tb/swk_cfg_chk.sv
`timescale 1ns/1ns
// ==========================================================
// Port-level checks on the wake configuration bank
// ==========================================================
module wake_cfg_chk (
  input wire CLK,
  input wire RST,
  input wire MODE_NORMAL,
  input wire MODE_STOP,
  input wire WAKE_EVENT,
  input wire [6:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire REG_RVALID,
  input wire BUS_TIMEOUT_EVENT,
  input wire BUS_TIMEOUT_FLAG,
  input wire INT_PULSE,
  input wire SELECTIVE_WAKE_EN,
  input wire CAL_ACTIVE,
  input wire RX_FRAME_VALID,
  input wire WAKE_FRAME_MATCH
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ==========================================================
  // Read-back of reserved bits
  // ==========================================================
  AST_CTRL_RSVD: assert property (REG_RD && REG_ADDR == 7'h20 |=> REG_RVALID && REG_RDATA[3:1] == 3'h0)
    else $error("control reserved bits not zero");
  AST_SAMPLE_RSVD: assert property (REG_RD && REG_ADDR == 7'h22 |=> REG_RVALID && REG_RDATA[7:6] == 2'h0)
    else $error("sample point reserved bits not zero");
  AST_LOW_RSVD: assert property (REG_RD && REG_ADDR == 7'h26 |=> REG_RVALID && !REG_RDATA[7])
    else $error("identifier low reserved bit not zero");

  // ==========================================================
  // Valid bit and wake enable
  // ==========================================================
  // A quiet cycle after the cause keeps a fresh software set out of the window
  AST_WAKE_CLEARS: assert property (WAKE_EVENT && !REG_WR ##1 !REG_WR |=> !SELECTIVE_WAKE_EN)
    else $error("wake enable survived a wake-up");
  AST_STOP_WRITE: assert property (MODE_STOP && REG_WR && REG_ADDR >= 7'h20 && REG_ADDR <= 7'h27
    ##1 !REG_WR |=> !SELECTIVE_WAKE_EN)
    else $error("wake enable survived a stop-mode write");
  AST_EN_NEEDS_MODE: assert property (!MODE_NORMAL && !MODE_STOP |=> !SELECTIVE_WAKE_EN)
    else $error("wake enabled outside normal and stop");

  // ==========================================================
  // Time-out, calibration and frame match causes
  // ==========================================================
  AST_IRQ_CAUSE: assert property (INT_PULSE |-> $past(BUS_TIMEOUT_EVENT))
    else $error("interrupt without a time-out");
  AST_FLAG_CAUSE: assert property ($rose(BUS_TIMEOUT_FLAG) |-> $past(BUS_TIMEOUT_EVENT)
    && $past(MODE_NORMAL || MODE_STOP))
    else $error("time-out flag set without cause");
  AST_CAL_CAUSE: assert property ($rose(CAL_ACTIVE) |-> $past(REG_WR, 2))
    else $error("calibration started without a write");
  AST_MATCH_CAUSE: assert property (WAKE_FRAME_MATCH |-> $past(RX_FRAME_VALID) && $past(SELECTIVE_WAKE_EN))
    else $error("match without an enabled frame");

  COV_IRQ: cover property (INT_PULSE);
  COV_MATCH: cover property (WAKE_FRAME_MATCH);
  COV_CAL: cover property ($rose(CAL_ACTIVE));
endmodule

bind can_selective_wake_config wake_cfg_chk chk_u (.*);

//--- tb/host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Microcontroller side of the register port
// ==========================================================
module host_model (
  input wire clk,
  input wire [7:0] rdata,
  input wire rvalid,
  output logic [6:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  output logic txd
);
  initial begin
    addr = 7'h7f;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    txd = 1'b1;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 7'h26) v[1] = 1'b0;
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
  endtask
  // Answer is taken one cycle after the request
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    ok = rvalid;
  endtask
  // Trim reference bursts, pin idles high between them
  task automatic tx_burst(input int half, input int edges);
    repeat (edges) begin
      @(posedge clk);
      txd <= 1'b0;
      repeat (half) @(posedge clk);
      txd <= 1'b1;
      repeat (half - 1) @(posedge clk);
    end
  endtask
endmodule

//--- tb/can_selective_wake_config_test.sv
`timescale 1ns/1ns
// ==========================================================
// Wake configuration bank testbench
// ==========================================================
module can_selective_wake_config_test;
  localparam P_CLR = 6'h01, P_TO = 6'h02, P_CAN = 6'h04, P_WAKE = 6'h08, P_SOFT = 6'h10, P_RST = 6'h20;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic MODE_NORMAL = 1'b1;
  logic MODE_STOP = 1'b0;
  logic RX_FRAME_VALID = 1'b0;
  logic RX_RTR = 1'b0;
  logic RX_IDE = 1'b0;
  logic [28:0] RX_IDENTIFIER = 29'h0;
  logic [5:0] pls = 6'h00;
  wire RESTART, SOFT_RESET, WAKE_EVENT, CAN_CONFIG_WRITE, BUS_TIMEOUT_EVENT, BUS_TIMEOUT_CLEAR;
  wire [6:0] REG_ADDR;
  wire REG_WR, REG_RD, REG_RVALID, TRANSMIT_DATA_PIN, BUS_TIMEOUT_FLAG, INT_PULSE, SELECTIVE_WAKE_EN;
  wire ALT_RECEIVER_EN, CAL_ACTIVE, TRIM_UPDATE, SAMPLE_STROBE, BIT_STROBE, WAKE_FRAME_MATCH;
  wire [7:0] REG_WDATA, REG_RDATA;
  wire [15:0] TRIM_PERIOD;
  logic [7:0] rd_val;
  logic rd_ok;
  logic [15:0] last_trim = 16'h0;
  int num_errors = 0, n_checks = 0, cycles = 0, last_bit = 0, bit_gap = 0, samp_off = 0;
  logic [7:0] dflt [8] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ones [8] = '{8'h00, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h7d, 8'hff};
  logic [28:0] ids [5] = '{{8'ha5, 3'h7, 18'h0}, {8'h55, 3'h7, 18'h0}, {8'ha5, 3'h7, 18'h3ffff},
    {8'ha4, 3'h7, 18'h0}, {8'ha5, 3'h6, 18'h0}};
  logic hits [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  assign {RESTART, SOFT_RESET, WAKE_EVENT, CAN_CONFIG_WRITE, BUS_TIMEOUT_EVENT, BUS_TIMEOUT_CLEAR} = pls;
  always #5 CLK = ~CLK;

  can_selective_wake_config dut_u (.*);
  host_model host_u (.clk(CLK), .rdata(REG_RDATA), .rvalid(REG_RVALID), .addr(REG_ADDR), .wr(REG_WR),
    .rd(REG_RD), .wdata(REG_WDATA), .txd(TRANSMIT_DATA_PIN));

  // Pulses the sequence cannot wait on, plus the hang limit
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (TRIM_UPDATE === 1'b1) last_trim <= TRIM_PERIOD;
    if (BIT_STROBE === 1'b1) begin
      bit_gap <= cycles - last_bit;
      last_bit <= cycles;
    end
    if (SAMPLE_STROBE === 1'b1) samp_off <= cycles - last_bit;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  // ==========================================================
  // Compare and drive helpers
  // ==========================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host_u.read_reg(a, rd_val, rd_ok);
    chk1(rd_ok, 1'b1);
    chk({8'h0, rd_val}, {8'h0, exp});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge CLK);
    pls <= m;
    @(posedge CLK);
    pls <= 6'h00;
    #1;
  endtask
  task automatic frame(input logic [28:0] id, input logic rtr, input logic ide, input logic exp);
    @(posedge CLK);
    RX_IDENTIFIER <= id;
    RX_RTR <= rtr;
    RX_IDE <= ide;
    RX_FRAME_VALID <= 1'b1;
    @(posedge CLK);
    RX_FRAME_VALID <= 1'b0;
    #1;
    chk1(WAKE_FRAME_MATCH, exp);
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(7'(7'h20 + i), dflt[i]);
    rchk(7'h10, 8'h00);
    // All-ones writes show the reserved and stored bits
    for (int i = 1; i < 8; i++) begin
      host_u.write_reg(7'(7'h20 + i), 8'hff);
      rchk(7'(7'h20 + i), ones[i]);
    end
    host_u.write_reg(7'h20, 8'hff);
    rchk(7'h20, 8'hf1);
    wt(2);
    chk1(CAL_ACTIVE, 1'b1);
    chk1(SELECTIVE_WAKE_EN, 1'b1);
    // Only the code 11 unlocks, option register follows it
    for (int k = 0; k < 4; k++) begin
      host_u.write_reg(7'h20, {1'b1, 2'(k), 5'h00});
      host_u.write_reg(7'h3f, 8'h01);
      wt(2);
      chk1(CAL_ACTIVE, k == 3);
      chk1(ALT_RECEIVER_EN, k == 3);
    end
    host_u.write_reg(7'h20, 8'h60);
    wt(2);
    chk1(CAL_ACTIVE, 1'b0);
    host_u.write_reg(7'h20, 8'he0);
    host_u.tx_burst(5, 3);
    wt(2);
    chk(last_trim, 16'h000a);
    // Time-out with and without the interrupt enable
    host_u.write_reg(7'h20, 8'h11);
    wt(2);
    pulse(P_TO);
    chk1(BUS_TIMEOUT_FLAG, 1'b1);
    chk1(INT_PULSE, 1'b1);
    pulse(P_CLR);
    host_u.write_reg(7'h20, 8'h01);
    pulse(P_TO);
    chk1(BUS_TIMEOUT_FLAG, 1'b1);
    chk1(INT_PULSE, 1'b0);
    pulse(P_CLR);
    host_u.write_reg(7'h20, 8'h10);
    wt(2);
    pulse(P_TO);
    chk1(BUS_TIMEOUT_FLAG, 1'b0);
    chk1(INT_PULSE, 1'b0);
    // Automatic clearing of the valid bit
    host_u.write_reg(7'h20, 8'h01);
    host_u.write_reg(7'h23, 8'h5a);
    rchk(7'h20, 8'h00);
    host_u.write_reg(7'h20, 8'h01);
    pulse(P_WAKE);
    rchk(7'h20, 8'h00);
    host_u.write_reg(7'h20, 8'h01);
    pulse(P_CAN);
    rchk(7'h20, 8'h01);
    @(posedge CLK);
    MODE_NORMAL <= 1'b0;
    MODE_STOP <= 1'b1;
    wt(2);
    chk1(SELECTIVE_WAKE_EN, 1'b1);
    pulse(P_CAN);
    rchk(7'h20, 8'h00);
    host_u.write_reg(7'h20, 8'h01);
    rchk(7'h20, 8'h00);
    @(posedge CLK);
    MODE_NORMAL <= 1'b1;
    MODE_STOP <= 1'b0;
    // Standard identifier, top nibble left out of the mask
    host_u.write_reg(7'h23, 8'ha5);
    host_u.write_reg(7'h24, 8'he0);
    host_u.write_reg(7'h25, 8'h00);
    host_u.write_reg(7'h26, 8'h00);
    host_u.write_reg(7'h27, 8'h0f);
    host_u.write_reg(7'h20, 8'h01);
    wt(2);
    for (int i = 0; i < 5; i++) frame(ids[i], 1'b0, 1'b0, hits[i]);
    frame(ids[0], 1'b1, 1'b0, 1'b0);
    frame(ids[0], 1'b0, 1'b1, 1'b0);
    // Valid but in neither mode: wake must drop
    @(posedge CLK);
    MODE_NORMAL <= 1'b0;
    wt(2);
    chk1(SELECTIVE_WAKE_EN, 1'b0);
    @(posedge CLK);
    MODE_NORMAL <= 1'b1;
    host_u.write_reg(7'h20, 8'h00);
    wt(2);
    frame(ids[0], 1'b0, 1'b0, 1'b0);
    // Bit length follows quanta count and clock select
    host_u.write_reg(7'h21, 8'h08);
    host_u.write_reg(7'h22, 8'h20);
    for (int s = 0; s < 2; s++) begin
      host_u.write_reg(7'h3e, 8'(s));
      host_u.write_reg(7'h20, 8'h01);
      wt(40);
      chk(16'(bit_gap), 16'(8 << s));
      // Half of eight quanta: sample lands five quanta after the bit strobe
      chk(16'(samp_off), 16'(5 << s));
    end
    // Restart keeps the upper nibble, soft reset restores defaults
    host_u.write_reg(7'h20, 8'h91);
    pulse(P_RST);
    rchk(7'h20, 8'h90);
    pulse(P_SOFT);
    rchk(7'h20, 8'h00);
    rchk(7'h21, 8'ha0);
    stop_test();
  end
endmodule
